/* ccit_consts.vh */
`ifndef CCIT_CONSTS_VH
`define CCIT_CONSTS_VH
// Register offsets
`define CCIT_ADDR_WDOG 8'h08
`define CCIT_ADDR_TGT 8'h09
`define CCIT_ADDR_OUT 8'h0a
`define CCIT_ADDR_IRQ_STAT 8'h10
`define CCIT_ADDR_IRQ_CLR 8'h11
`define CCIT_ADDR_IRQ_EN 8'h12
`define CCIT_ADDR_STATUS 8'h13
// Reset values
`define CCIT_RST_WDOG 8'hfe
`define CCIT_RST_TGT 8'h1e
`define CCIT_RST_OUT 8'h10
// Field positions
`define CCIT_WDOG_OFF_BIT 0
`define CCIT_TGT_BLOCK_BIT 7
`define CCIT_OUT_FAST_BIT 1
`define CCIT_OUT_BUSOFF_BIT 0
// Interrupt bits
`define CCIT_IRQ_CC_TIMEOUT 0
`define CCIT_IRQ_WR_BLOCKED 1
`define CCIT_IRQ_BUS_FREE 2
`define CCIT_IRQ_BUS_RECOVER 3
// Timing in ns, and recovery pulse count
`define CCIT_CLK_NS 4
`define CCIT_CC_STEP_NS 2000000
`define CCIT_HOLD_STEP_NS 50
`define CCIT_FILT_STEP_NS 5
`define CCIT_SETUP_BASE_NS 80
`define CCIT_SETUP_STEP_NS 640
`define CCIT_DLY_BASE_NS 240
`define CCIT_DLY_STEP_NS 40
`define CCIT_BUS_FAST_NS 50000
`define CCIT_BUS_SLOW_NS 1000000000
`define CCIT_SCL_HALF_NS 5000
`define CCIT_RECOVER_PULSES 9
`endif

/* ccit_top.v */
// Contract
// - Channel timeout: 7-bit field, 2 ms units
// - Terminate transaction when timeout expires
// - Timeout-off bit stops supervision
// - Block remote writes to local registers
// - Remote target accesses unaffected by block
// - SDA input hold is field times 50 ns
// - Reject SCL/SDA glitches up to field times 5 ns
// - ACK SDA setup 80 ns plus 640 ns units
// - SDA output delay 240 ns plus 40 ns steps
// - Bus watchdog 50 us fast, 1 s slow
// - Bus-timer-off bit disables bus watchdog
// - SDA high and idle: bus free
// - SDA low and idle: nine SCL pulses
`timescale 1ns/1ps
`include "ccit_consts.vh"
module ccit_top #(
    parameter CC_STEP_CYC = `CCIT_CC_STEP_NS / `CCIT_CLK_NS,
    parameter BUS_FAST_CYC = `CCIT_BUS_FAST_NS / `CCIT_CLK_NS,
    parameter BUS_SLOW_CYC = `CCIT_BUS_SLOW_NS / `CCIT_CLK_NS,
    parameter SCL_HALF_CYC = `CCIT_SCL_HALF_NS / `CCIT_CLK_NS
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Control channel transaction side
    input wire cc_start,
    input wire cc_done,
    input wire cc_remote,
    input wire cc_is_write,
    input wire cc_local_reg,
    output reg cc_abort,
    output reg cc_wr_allow,
    output reg cc_active,
    // Target-side SDA output request during remote accesses
    input wire tgt_sda_out,
    input wire tgt_ack_cycle,
    // Local I2C pins
    input wire scl_in,
    input wire sda_in,
    output reg scl_out,
    output reg scl_oe,
    output reg sda_out,
    output reg sda_oe,
    // Filtered and held bus view
    output reg scl_filt,
    output reg sda_filt,
    output reg sda_held,
    output reg bus_free,
    // Interrupt
    output reg irq
);

localparam integer HOLD_STEP_CYC = (`CCIT_HOLD_STEP_NS + `CCIT_CLK_NS - 1) / `CCIT_CLK_NS;
localparam integer FILT_STEP_NS = `CCIT_FILT_STEP_NS;
localparam integer SETUP_BASE_CYC = (`CCIT_SETUP_BASE_NS + `CCIT_CLK_NS - 1) / `CCIT_CLK_NS;
localparam integer SETUP_STEP_CYC = `CCIT_SETUP_STEP_NS / `CCIT_CLK_NS;
localparam integer DLY_BASE_CYC = `CCIT_DLY_BASE_NS / `CCIT_CLK_NS;
localparam integer DLY_STEP_CYC = `CCIT_DLY_STEP_NS / `CCIT_CLK_NS;
localparam RS_IDLE = 2'd0;
localparam RS_LOW = 2'd1;
localparam RS_HIGH = 2'd2;

// Glitch filter width in clocks, rounded up
function [7:0] filt_cycles;
    input [3:0] depth;
    begin
        filt_cycles = (({4'h0, depth} * FILT_STEP_NS[7:0]) + 8'd3) >> 2;
    end
endfunction

reg [7:0] wdog_q;
reg [7:0] tgt_q;
reg [7:0] out_q;
reg [3:0] ist_q;
reg [3:0] ien_q;

////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [1:0] scl_s_q;
reg [1:0] sda_s_q;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        scl_s_q <= 2'b11;
        sda_s_q <= 2'b11;
    end else begin
        scl_s_q <= {scl_s_q[0], scl_in};
        sda_s_q <= {sda_s_q[0], sda_in};
    end
end
wire scl_sync = scl_s_q[1];
wire sda_sync = sda_s_q[1];

////////////////////////////////////////////////////////////////////////
// Glitch filters: a new level must stand longer than the filter width
reg [7:0] scl_fc_q;
reg [7:0] sda_fc_q;
wire [7:0] filt_w = filt_cycles(tgt_q[3:0]);
always @(posedge clk or posedge rst) begin
    if (rst) begin
        scl_fc_q <= 8'h00;
        sda_fc_q <= 8'h00;
        scl_filt <= 1'b1;
        sda_filt <= 1'b1;
    end else begin
        if (scl_sync == scl_filt) begin
            scl_fc_q <= 8'h00;
        end else if (scl_fc_q >= filt_w) begin
            scl_filt <= scl_sync;
            scl_fc_q <= 8'h00;
        end else begin
            scl_fc_q <= scl_fc_q + 8'h01;
        end
        if (sda_sync == sda_filt) begin
            sda_fc_q <= 8'h00;
        end else if (sda_fc_q >= filt_w) begin
            sda_filt <= sda_sync;
            sda_fc_q <= 8'h00;
        end else begin
            sda_fc_q <= sda_fc_q + 8'h01;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// SDA input hold: after SCL falls, the held view keeps its level
reg scl_f_q;
reg [6:0] hold_q;
wire scl_fall = scl_f_q & ~scl_filt;
wire scl_rise = ~scl_f_q & scl_filt;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        scl_f_q <= 1'b1;
        hold_q <= 7'h00;
        sda_held <= 1'b1;
    end else begin
        scl_f_q <= scl_filt;
        if (scl_fall) begin
            hold_q <= {4'h0, tgt_q[6:4]} * HOLD_STEP_CYC[6:0];
        end else if (hold_q != 7'h00) begin
            hold_q <= hold_q - 7'h01;
        end else begin
            sda_held <= sda_filt;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Control channel watchdog
reg [31:0] cc_pre_q;
reg [6:0] cc_units_q;
wire cc_off = wdog_q[`CCIT_WDOG_OFF_BIT];
reg cc_expire;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        cc_active <= 1'b0;
        cc_pre_q <= 32'h0;
        cc_units_q <= 7'h00;
        cc_abort <= 1'b0;
        cc_expire <= 1'b0;
    end else begin
        cc_abort <= 1'b0;
        cc_expire <= 1'b0;
        if (cc_start) begin
            cc_active <= 1'b1;
            cc_pre_q <= 32'h0;
            cc_units_q <= 7'h00;
        end else if (cc_done) begin
            cc_active <= 1'b0;
        end else if (cc_active && !cc_off) begin
            if (cc_pre_q == CC_STEP_CYC - 1) begin
                cc_pre_q <= 32'h0;
                if (cc_units_q + 7'h01 >= wdog_q[7:1]) begin
                    cc_expire <= 1'b1;
                    cc_abort <= 1'b1;
                    cc_active <= 1'b0;
                end else begin
                    cc_units_q <= cc_units_q + 7'h01;
                end
            end else begin
                cc_pre_q <= cc_pre_q + 32'h1;
            end
        end
    end
end

// Remote writes to local registers are held off; target accesses pass
wire blk = tgt_q[`CCIT_TGT_BLOCK_BIT] & cc_remote & cc_is_write & cc_local_reg;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        cc_wr_allow <= 1'b1;
    end else begin
        cc_wr_allow <= ~blk;
    end
end

////////////////////////////////////////////////////////////////////////
// SDA output timing in remote accesses
reg [7:0] sdly_q;
reg sda_pend_q;
reg sda_want_q;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        sdly_q <= 8'h00;
        sda_pend_q <= 1'b0;
        sda_want_q <= 1'b1;
    end else if (tgt_sda_out != sda_want_q && !sda_pend_q) begin
        sda_want_q <= tgt_sda_out;
        sda_pend_q <= 1'b1;
        sdly_q <= DLY_BASE_CYC[7:0] + out_q[3:2] * DLY_STEP_CYC[7:0];
    end else if (sda_pend_q) begin
        if (sdly_q == 8'h00) begin
            sda_pend_q <= 1'b0;
        end else begin
            sdly_q <= sdly_q - 8'h01;
        end
    end
end

// Setup time before SCL rise in ACK cycles, for the SCL stretch logic
reg [11:0] setup_q;
reg scl_stretch_q;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        setup_q <= 12'h000;
        scl_stretch_q <= 1'b0;
    end else if (tgt_ack_cycle && cc_active && scl_fall) begin
        setup_q <= SETUP_BASE_CYC[11:0] + out_q[7:4] * SETUP_STEP_CYC[11:0];
        scl_stretch_q <= 1'b1;
    end else if (setup_q != 12'h000) begin
        setup_q <= setup_q - 12'h001;
    end else begin
        scl_stretch_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Bus watchdog and recovery
reg [31:0] bus_cnt_q;
reg [1:0] rs_q;
reg [15:0] half_q;
reg [3:0] pulses_q;
reg bus_free_ev;
reg bus_rec_ev;
wire bus_off = out_q[`CCIT_OUT_BUSOFF_BIT];
wire [31:0] bus_lim = out_q[`CCIT_OUT_FAST_BIT] ? BUS_FAST_CYC : BUS_SLOW_CYC;
wire bus_act = scl_fall | scl_rise | (sda_filt != sda_held);
always @(posedge clk or posedge rst) begin
    if (rst) begin
        bus_cnt_q <= 32'h0;
        rs_q <= RS_IDLE;
        half_q <= 16'h0;
        pulses_q <= 4'h0;
        bus_free <= 1'b0;
        scl_out <= 1'b1;
        scl_oe <= 1'b0;
        bus_free_ev <= 1'b0;
        bus_rec_ev <= 1'b0;
    end else begin
        bus_free_ev <= 1'b0;
        bus_rec_ev <= 1'b0;
        case (rs_q)
        RS_IDLE: begin
            scl_oe <= scl_stretch_q;
            scl_out <= ~scl_stretch_q;
            if (bus_off || bus_act) begin
                bus_cnt_q <= 32'h0;
                bus_free <= bus_free & ~bus_act;
            end else if (bus_cnt_q >= bus_lim - 1) begin
                bus_cnt_q <= 32'h0;
                if (sda_filt) begin
                    bus_free_ev <= ~bus_free;
                    bus_free <= 1'b1;
                end else begin
                    bus_rec_ev <= 1'b1;
                    rs_q <= RS_LOW;
                    pulses_q <= 4'h0;
                    half_q <= 16'h0;
                end
            end else begin
                bus_cnt_q <= bus_cnt_q + 32'h1;
            end
        end
        RS_LOW: begin
            scl_oe <= 1'b1;
            scl_out <= 1'b0;
            if (half_q == SCL_HALF_CYC - 1) begin
                half_q <= 16'h0;
                rs_q <= RS_HIGH;
            end else begin
                half_q <= half_q + 16'h1;
            end
        end
        RS_HIGH: begin
            scl_oe <= 1'b0;
            scl_out <= 1'b1;
            if (half_q == SCL_HALF_CYC - 1) begin
                half_q <= 16'h0;
                pulses_q <= pulses_q + 4'h1;
                rs_q <= (pulses_q == `CCIT_RECOVER_PULSES - 1) ? RS_IDLE : RS_LOW;
            end else begin
                half_q <= half_q + 16'h1;
            end
        end
        default: rs_q <= RS_IDLE;
        endcase
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        sda_out <= 1'b1;
        sda_oe <= 1'b0;
    end else begin
        sda_out <= 1'b0;
        sda_oe <= cc_active & ~sda_want_q & ~sda_pend_q;
    end
end

////////////////////////////////////////////////////////////////////////
// Registers and interrupts
wire [3:0] ev = {bus_rec_ev, bus_free_ev, blk & cc_start, cc_expire};
wire [3:0] clr = (reg_wr && reg_addr == `CCIT_ADDR_IRQ_CLR) ? reg_wdata[3:0] : 4'h0;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        wdog_q <= `CCIT_RST_WDOG;
        tgt_q <= `CCIT_RST_TGT;
        out_q <= `CCIT_RST_OUT;
        ien_q <= 4'h0;
        ist_q <= 4'h0;
        reg_rdata <= 8'h00;
        irq <= 1'b0;
    end else begin
        if (reg_wr) begin
            case (reg_addr)
            `CCIT_ADDR_WDOG: wdog_q <= reg_wdata;
            `CCIT_ADDR_TGT: tgt_q <= reg_wdata;
            `CCIT_ADDR_OUT: out_q <= reg_wdata;
            `CCIT_ADDR_IRQ_EN: ien_q <= reg_wdata[3:0];
            default: ien_q <= ien_q;
            endcase
        end
        ist_q <= (ist_q & ~clr) | ev;
        irq <= |(((ist_q & ~clr) | ev) & ien_q);
        reg_rdata <= 8'h00;
        if (reg_rd) begin
            case (reg_addr)
            `CCIT_ADDR_WDOG: reg_rdata <= wdog_q;
            `CCIT_ADDR_TGT: reg_rdata <= tgt_q;
            `CCIT_ADDR_OUT: reg_rdata <= out_q;
            `CCIT_ADDR_IRQ_STAT: reg_rdata <= {4'h0, ist_q};
            `CCIT_ADDR_IRQ_EN: reg_rdata <= {4'h0, ien_q};
            `CCIT_ADDR_STATUS: reg_rdata <= {4'h0, rs_q != RS_IDLE, bus_free, cc_abort, cc_active};
            default: reg_rdata <= 8'h00;
            endcase
        end
    end
end

endmodule // ccit_top

/* ccit_monitor.sv */
`timescale 1ns/1ps
`include "ccit_consts.vh"
module ccit_monitor #(
    parameter CC_STEP_CYC = 20,
    parameter SCL_HALF_CYC = 5
) (
    // Clock, reset, register port
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Control channel
    input wire cc_start,
    input wire cc_done,
    input wire cc_remote,
    input wire cc_is_write,
    input wire cc_local_reg,
    input wire cc_abort,
    input wire cc_wr_allow,
    input wire cc_active,
    // Bus side
    input wire scl_oe,
    input wire sda_filt,
    input wire bus_free
);
    reg [6:0] tmo_q;
    reg blk_q;
    reg [31:0] run_q;
    reg [31:0] age_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tmo_q <= 7'h7f;
            blk_q <= 1'b0;
            run_q <= 32'h0;
            age_q <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `CCIT_ADDR_WDOG) tmo_q <= reg_wdata[7:1];
            if (reg_wr && reg_addr == `CCIT_ADDR_TGT) blk_q <= reg_wdata[7];
            run_q <= scl_oe ? run_q + 1 : 32'h0;
            age_q <= cc_start ? 32'h0 : age_q + 1;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_abort_once;
        cc_abort ##1 !cc_abort;
    endsequence
    a_abort_pulse: assert property (cc_abort |-> s_abort_once)
        else $error("abort longer than one cycle");
    a_abort_time: assert property (cc_abort |-> age_q + 2 >= tmo_q * CC_STEP_CYC
        && age_q <= tmo_q * CC_STEP_CYC + 2) else $error("abort at wrong time");
    a_start_active: assert property (cc_start |=> cc_active)
        else $error("start did not raise active");
    a_done_clear: assert property (cc_done && !cc_start |=> !cc_active)
        else $error("done did not clear active");
    a_write_block: assert property (cc_start && cc_remote && cc_is_write && cc_local_reg
        && blk_q |=> !cc_wr_allow) else $error("blocked write allowed");
    a_target_pass: assert property (cc_start && cc_remote && !cc_local_reg
        |=> cc_wr_allow) else $error("target access refused");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_scl_half: assert property ($fell(scl_oe) |-> run_q == SCL_HALF_CYC)
        else $error("recovery low phase wrong");
    a_free_high: assert property ($rose(bus_free) |-> sda_filt)
        else $error("bus free with data low");
endmodule // ccit_monitor
bind ccit_top ccit_monitor #(.CC_STEP_CYC(CC_STEP_CYC), .SCL_HALF_CYC(SCL_HALF_CYC)) mon_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cc_start(cc_start), .cc_done(cc_done),
    .cc_remote(cc_remote), .cc_is_write(cc_is_write), .cc_local_reg(cc_local_reg),
    .cc_abort(cc_abort), .cc_wr_allow(cc_wr_allow), .cc_active(cc_active),
    .scl_oe(scl_oe), .sda_filt(sda_filt), .bus_free(bus_free));

/* ccit_bus_model.sv */
`timescale 1ns/1ps
module ccit_bus_model (
    // Device pins
    input wire scl_out,
    input wire scl_oe,
    input wire sda_out,
    input wire sda_oe,
    output wire scl_in,
    output wire sda_in,
    // Bench control
    input wire link_run,
    input wire sda_stuck,
    output integer pulses
);
    reg scl_ext;
    initial scl_ext = 1'b1;
    initial pulses = 0;
    // Remote clock stands high outside bursts
    always #40 scl_ext = link_run ? ~scl_ext : 1'b1;
    // Both lines pulled up, any driver pulls low
    assign scl_in = scl_ext & ~(scl_oe & ~scl_out);
    assign sda_in = ~sda_stuck & ~(sda_oe & ~sda_out);
    always @(posedge scl_in) if (!link_run) pulses = pulses + 1;
endmodule // ccit_bus_model

/* tb_control_channel_i2c_timing.sv */
`timescale 1ns/1ps
`include "ccit_consts.vh"
module tb_control_channel_i2c_timing;
    reg clk, rst, reg_wr, reg_rd, cc_start, cc_done, cc_remote, cc_is_write, cc_local_reg;
    reg link_run, sda_stuck, tgt_sda_out, tgt_ack_cycle;
    reg [7:0] reg_addr, reg_wdata, d;
    wire [7:0] reg_rdata;
    wire cc_abort, cc_wr_allow, cc_active, scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
    wire scl_filt, sda_filt, sda_held, bus_free, irq;
    integer pulses, err_count, tests_run, n, a0;
    ccit_top #(.CC_STEP_CYC(20), .BUS_FAST_CYC(50), .BUS_SLOW_CYC(200), .SCL_HALF_CYC(5)) dut_u (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cc_start(cc_start), .cc_done(cc_done),
        .cc_remote(cc_remote), .cc_is_write(cc_is_write), .cc_local_reg(cc_local_reg),
        .cc_abort(cc_abort), .cc_wr_allow(cc_wr_allow), .cc_active(cc_active),
        .tgt_sda_out(tgt_sda_out), .tgt_ack_cycle(tgt_ack_cycle), .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .scl_filt(scl_filt), .sda_filt(sda_filt), .sda_held(sda_held), .bus_free(bus_free),
        .irq(irq));
    ccit_bus_model bus_u (.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in), .link_run(link_run),
        .sda_stuck(sda_stuck), .pulses(pulses));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////
    task chk(input string name, input [7:0] seen, input [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task cc_pulse(input bit done);
        @(posedge clk);
        if (done) cc_done <= 1'b1;
        else cc_start <= 1'b1;
        @(posedge clk);
        cc_done <= 1'b0;
        cc_start <= 1'b0;
    endtask
    task idle(input integer c);
        repeat (c) @(posedge clk);
    endtask
    task conclude;
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////
    task test_bus;
        n = 0;
        while (bus_free !== 1'b1 && n < 400) begin
            @(posedge clk);
            n = n + 1;
        end
        chk("free_time", n >= 195 && n <= 215, 1);
        link_run <= 1'b1;
        n = 0;
        repeat (150) @(posedge clk) if (scl_filt !== 1'b1) n = n + 1;
        chk("glitch_cut", n == 0, 1);
        wr(`CCIT_ADDR_TGT, 8'h11);
        n = 0;
        repeat (150) @(posedge clk) if (scl_filt !== 1'b1) n = n + 1;
        chk("pulse_pass", n != 0, 1);
        link_run <= 1'b0;
        wr(`CCIT_ADDR_TGT, 8'h1e);
        wr(`CCIT_ADDR_OUT, 8'h12);
        a0 = pulses;
        sda_stuck <= 1'b1;
        n = 0;
        while (pulses - a0 < 9 && n < 1000) begin
            @(posedge clk);
            n = n + 1;
        end
        sda_stuck <= 1'b0;
        idle(40);
        chk("pulses", pulses - a0, 9);
        rd(`CCIT_ADDR_IRQ_STAT);
        chk("rec_stat", d[3], 1);
        $display("test bus done");
    endtask
    task test_regs;
        rd(`CCIT_ADDR_WDOG);
        chk("wdog_rst", d, 8'hfe);
        rd(`CCIT_ADDR_TGT);
        chk("tgt_rst", d, 8'h1e);
        wr(`CCIT_ADDR_OUT, 8'h1c);
        rd(`CCIT_ADDR_OUT);
        chk("out_rw", d, 8'h1c);
        rd(`CCIT_ADDR_IRQ_CLR);
        chk("clr_wo", d, 8'h00);
        rd(8'h20);
        chk("unmapped", d, 8'h00);
        $display("test regs done");
    endtask
    task test_cc;
        wr(`CCIT_ADDR_WDOG, 8'h04);
        wr(`CCIT_ADDR_IRQ_EN, 8'h01);
        cc_pulse(0);
        idle(30);
        cc_pulse(0);
        n = 0;
        while (cc_abort !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n = n + 1;
        end
        chk("abort_time", n >= 39 && n <= 42, 1);
        idle(3);
        chk("irq_on", irq, 1);
        wr(`CCIT_ADDR_IRQ_EN, 8'h00);
        idle(2);
        chk("irq_mask", irq, 0);
        wr(`CCIT_ADDR_IRQ_EN, 8'h01);
        wr(`CCIT_ADDR_IRQ_CLR, 8'h01);
        idle(2);
        chk("irq_clr", irq, 0);
        cc_pulse(0);
        idle(20);
        cc_pulse(1);
        a0 = n;
        n = 0;
        repeat (60) @(posedge clk) if (cc_abort !== 1'b0) n = n + 1;
        chk("done_quiet", n, 0);
        wr(`CCIT_ADDR_WDOG, 8'h05);
        cc_pulse(0);
        n = 0;
        repeat (100) @(posedge clk) if (cc_abort !== 1'b0) n = n + 1;
        chk("off_quiet", n, 0);
        chk("off_active", cc_active, 1);
        cc_pulse(1);
        $display("test cc done");
    endtask
    task test_block;
        cc_remote <= 1'b1;
        cc_is_write <= 1'b1;
        cc_local_reg <= 1'b1;
        wr(`CCIT_ADDR_TGT, 8'h9e);
        cc_pulse(0);
        idle(2);
        chk("blocked", cc_wr_allow, 0);
        cc_local_reg <= 1'b0;
        cc_pulse(0);
        idle(2);
        chk("target_ok", cc_wr_allow, 1);
        wr(`CCIT_ADDR_TGT, 8'h1e);
        cc_local_reg <= 1'b1;
        cc_pulse(0);
        idle(2);
        chk("unblocked", cc_wr_allow, 1);
        cc_pulse(1);
        $display("test block done");
    endtask
    task test_sda;
        wr(`CCIT_ADDR_OUT, 8'h14);
        wr(`CCIT_ADDR_WDOG, 8'h05);
        cc_pulse(0);
        tgt_sda_out <= 1'b0;
        n = 0;
        while (sda_oe !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n = n + 1;
        end
        chk("sda_delay", n >= 70 && n <= 76, 1);
        @(posedge clk);
        tgt_sda_out <= 1'b1;
        cc_pulse(1);
        idle(4);
        chk("sda_release", sda_oe, 0);
        $display("test sda done");
    endtask
    initial begin
        #100000;
        err_count = err_count + 1;
        conclude;
    end
    initial begin
        {rst, reg_wr, reg_rd, cc_start, cc_done, cc_remote, cc_is_write} = 7'h40;
        {cc_local_reg, link_run, sda_stuck, reg_addr, reg_wdata} = 19'h0;
        tgt_sda_out = 1'b1;
        tgt_ack_cycle = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_bus;
        test_regs;
        test_cc;
        test_block;
        test_sda;
        conclude;
    end
endmodule // tb_control_channel_i2c_timing
